// ---- buck_mode_controller.sv ----
// mode and gate control state machine for a synchronous step-down converter
//
// Contract
// - pwm: high on each cycle, off on trip
// - pwm: low-side on during off portion
// - peak current limit ends high-side on-time
// - short: hold low-side until current decays
// - light-load flag 32 cycles enters pfm
// - pfm idle below upper threshold: high on
// - pfm high ends at threshold or peak
// - pfm: low-side on until zero current
// - below threshold after zero: pulse again
// - at threshold: low-side to zero, sleep
// - below exit threshold returns to pwm
// - enable low turns everything off
// - soft start only on qualified enable rise
// - soft start raises limit in four steps
`include "buck_mode_params.svh"
module buck_mode_controller #(
	parameter logic [7:0] SS_STEP_CYCLES = `BMC_SS_STEP_CYCLES
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// enable pin and supply monitor
	input wire logic i_en,
	input wire logic i_supply_ok,
	// comparator flags
	input wire logic i_reg_trip,
	input wire logic i_cur_limit,
	input wire logic i_zero_cur,
	input wire logic i_light_load,
	input wire logic pfm_peak_current_limit_peak_current_limit,
	input wire logic i_out_above_high,
	input wire logic pfm_peak_current_limit_exit_threshold,
	input wire logic i_short_det,
	input wire logic i_low_current,
	// power stage and analog control
	output logic o_high_gate,
	output logic o_low_gate,
	output logic o_pfm_mode,
	output logic o_sleep,
	output logic o_bias_en,
	output logic o_soft_start,
	output logic [1:0] o_ilim_step
);
	typedef buck_mode_pkg::state_t st_t;

	function automatic logic is_high(input st_t s);
		is_high = (s == buck_mode_pkg::PWM_HIGH) || (s == buck_mode_pkg::PFM_HIGH);
	endfunction : is_high

	function automatic logic is_low(input st_t s);
		is_low = (s == buck_mode_pkg::PWM_LOW) || (s == buck_mode_pkg::TIMED_LIMIT) ||
			(s == buck_mode_pkg::PFM_LOW);
	endfunction : is_low

	function automatic logic is_pfm(input st_t s);
		is_pfm = (s == buck_mode_pkg::PFM_SLEEP) || (s == buck_mode_pkg::PFM_HIGH) ||
			(s == buck_mode_pkg::PFM_LOW);
	endfunction : is_pfm

	buck_mode_pkg::flags_t raw;
	buck_mode_pkg::flags_t sync1_q;
	buck_mode_pkg::flags_t sync2_q;
	buck_mode_pkg::flags_t f;
	st_t state_q;
	st_t state_d;
	logic en_prev_q;
	logic run_q;
	logic run_d;
	logic en_rise;
	logic live;
	logic [3:0] osc_cnt_q;
	logic [3:0] osc_cnt_d;
	logic osc_tick;
	logic [5:0] qual_cnt_q;
	logic [5:0] qual_cnt_d;
	logic qual_done;
	logic light;
	logic [1:0] ss_step_q;
	logic [1:0] ss_step_d;
	logic [7:0] ss_cnt_q;
	logic [7:0] ss_cnt_d;
	logic ss_adv;

	// every flag crosses in through two flops before any logic sees it
	assign raw = {i_en, i_supply_ok, i_reg_trip, i_cur_limit, i_zero_cur, i_light_load,
		pfm_peak_current_limit_peak_current_limit, i_out_above_high, pfm_peak_current_limit_exit_threshold, i_short_det,
		i_low_current};
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= raw;
			sync2_q <= sync1_q;
		end
	end
	assign f = sync2_q;

	// a rise of enable only arms the block if the supply was already good
	assign en_rise = f.en & ~en_prev_q;
	assign run_d = f.en & (run_q | (en_rise & f.supply_ok));
	assign live = f.en & run_q;

	// oscillator cycle counter; a tick marks the last clock of each cycle
	assign osc_tick = (osc_cnt_q == `BMC_OSC_LAST);
	assign osc_cnt_d = (!live || osc_tick) ? 4'h0 : osc_cnt_q + 4'h1;

	// light-load qualification, restarted by any gap in which both flags are low
	assign light = f.zero_cur | f.light_load;
	assign qual_done = (qual_cnt_q == `BMC_QUAL_CYCLES);
	assign qual_cnt_d = (!live || !light || is_pfm(state_q)) ? 6'h0 :
		(osc_tick && !qual_done) ? qual_cnt_q + 6'h1 : qual_cnt_q;

	// soft-start step, held at the full limit once there
	assign ss_adv = osc_tick && (ss_cnt_q == SS_STEP_CYCLES - 8'h1);
	assign ss_step_d = !live ? `BMC_ILIM_MIN :
		(ss_step_q != `BMC_ILIM_FULL && ss_adv) ? ss_step_q + 2'h1 : ss_step_q;
	assign ss_cnt_d = (!live || ss_step_q == `BMC_ILIM_FULL || ss_adv) ? 8'h0 :
		osc_tick ? ss_cnt_q + 8'h1 : ss_cnt_q;

	// next state; shutdown overrides everything and acts as a reset
	always_comb begin
		state_d = state_q;
		if (!live) begin
			state_d = buck_mode_pkg::SHUTDOWN;
		end else begin
			case (state_q)
				buck_mode_pkg::SHUTDOWN: begin
					state_d = buck_mode_pkg::PWM_HIGH;
				end
				buck_mode_pkg::PWM_HIGH: begin
					if (f.short_det)
						state_d = buck_mode_pkg::TIMED_LIMIT;
					else if (f.cur_limit || f.reg_trip)
						state_d = buck_mode_pkg::PWM_LOW;
				end
				buck_mode_pkg::PWM_LOW: begin
					if (f.short_det)
						state_d = buck_mode_pkg::TIMED_LIMIT;
					else if (osc_tick && qual_done)
						state_d = buck_mode_pkg::PFM_SLEEP;
					else if (osc_tick)
						state_d = buck_mode_pkg::PWM_HIGH;
				end
				buck_mode_pkg::TIMED_LIMIT: begin
					// low-side stays on past the cycle edge so the current can decay
					if (f.low_current)
						state_d = buck_mode_pkg::PWM_LOW;
				end
				buck_mode_pkg::PFM_SLEEP: begin
					if (f.pfm_exit_threshold)
						state_d = buck_mode_pkg::PWM_HIGH;
					else if (!f.out_above_high)
						state_d = buck_mode_pkg::PFM_HIGH;
				end
				buck_mode_pkg::PFM_HIGH: begin
					if (f.pfm_exit_threshold)
						state_d = buck_mode_pkg::PWM_HIGH;
					else if (f.out_above_high || f.pfm_peak_current_limit || f.cur_limit)
						state_d = buck_mode_pkg::PFM_LOW;
				end
				buck_mode_pkg::PFM_LOW: begin
					if (f.pfm_exit_threshold)
						state_d = buck_mode_pkg::PWM_LOW;
					else if (f.zero_cur && f.out_above_high)
						state_d = buck_mode_pkg::PFM_SLEEP;
					else if (f.zero_cur)
						state_d = buck_mode_pkg::PFM_HIGH;
				end
				default: begin
					state_d = buck_mode_pkg::SHUTDOWN;
				end
			endcase
		end
	end

	// control state and counters
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			state_q <= buck_mode_pkg::SHUTDOWN;
			en_prev_q <= 1'b0;
			run_q <= 1'b0;
			osc_cnt_q <= 4'h0;
			qual_cnt_q <= 6'h0;
			ss_step_q <= `BMC_ILIM_MIN;
			ss_cnt_q <= 8'h0;
		end else begin
			state_q <= state_d;
			en_prev_q <= f.en;
			run_q <= run_d;
			osc_cnt_q <= osc_cnt_d;
			qual_cnt_q <= qual_cnt_d;
			ss_step_q <= ss_step_d;
			ss_cnt_q <= ss_cnt_d;
		end
	end

	// outputs registered from the next state so gates never glitch
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_high_gate <= 1'b0;
			o_low_gate <= 1'b0;
			o_pfm_mode <= 1'b0;
			o_sleep <= 1'b0;
			o_bias_en <= 1'b0;
			o_soft_start <= 1'b0;
			o_ilim_step <= `BMC_ILIM_MIN;
		end else begin
			o_high_gate <= is_high(state_d);
			o_low_gate <= is_low(state_d);
			o_pfm_mode <= is_pfm(state_d);
			o_sleep <= (state_d == buck_mode_pkg::PFM_SLEEP);
			o_bias_en <= (state_d != buck_mode_pkg::SHUTDOWN);
			o_soft_start <= live && (ss_step_d != `BMC_ILIM_FULL);
			o_ilim_step <= ss_step_d;
		end
	end

	// checks on the control sequence
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	sequence s_park_done;
		live && state_q == buck_mode_pkg::PFM_LOW && f.zero_cur && f.out_above_high &&
			!f.pfm_exit_threshold;
	endsequence
	sequence s_pfm_idle_low;
		live && state_q == buck_mode_pkg::PFM_SLEEP && !f.out_above_high &&
			!f.pfm_exit_threshold;
	endsequence

	chk_pwm_cycle_start: assert property (
		live && state_q == buck_mode_pkg::PWM_LOW && osc_tick && !qual_done && !f.short_det
		|=> o_high_gate && !o_low_gate) else $error("pwm cycle did not start high-side");
	chk_limit_ends_on: assert property (
		live && state_q == buck_mode_pkg::PWM_HIGH && f.cur_limit && !f.short_det
		|=> !o_high_gate && o_low_gate) else $error("current limit did not end on-time");
	chk_short_hold: assert property (
		live && state_q == buck_mode_pkg::TIMED_LIMIT && !f.low_current
		|=> o_low_gate && !o_high_gate) else $error("timed limit released early");
	chk_qual_restart: assert property (
		!light |=> qual_cnt_q == 6'h0) else $error("qualification not restarted");
	chk_pfm_entry: assert property (
		live && state_q == buck_mode_pkg::PWM_LOW && osc_tick && qual_done && !f.short_det
		|=> o_pfm_mode && o_sleep) else $error("pfm not entered after qualification");
	chk_pfm_start: assert property (
		s_pfm_idle_low |=> o_high_gate && o_pfm_mode) else $error("pfm pulse not started");
	chk_pfm_high_end: assert property (
		live && state_q == buck_mode_pkg::PFM_HIGH && !f.pfm_exit_threshold &&
		f.pfm_peak_current_limit |=> o_low_gate && !o_high_gate)
		else $error("pfm high-side not ended");
	chk_pfm_park_sleep: assert property (
		s_park_done |=> o_sleep && !o_high_gate && !o_low_gate) else $error("no sleep");
	chk_pfm_exit: assert property (
		live && is_pfm(state_q) && f.pfm_exit_threshold |=> !o_pfm_mode)
		else $error("pfm exit ignored");
	chk_shutdown_off: assert property (
		!f.en |=> !o_high_gate && !o_low_gate && !o_bias_en && o_ilim_step == `BMC_ILIM_MIN)
		else $error("shutdown left logic running");
	chk_start_qualified: assert property (
		!run_q && !(en_rise && f.supply_ok) |=> !run_q) else $error("unqualified start");
	chk_ss_advance: assert property (
		live && ss_step_q != `BMC_ILIM_FULL && ss_adv |=> ss_step_q == $past(ss_step_q) + 2'h1)
		else $error("soft-start step did not advance");
endmodule : buck_mode_controller

// ---- buck_mode_params.svh ----
// timing counts and field values for the buck mode controller
`ifndef BUCK_MODE_PARAMS_SVH
`define BUCK_MODE_PARAMS_SVH
// clock period and oscillator period, both in ns
`define BMC_CLK_PERIOD_NS 100
`define BMC_OSC_PERIOD_NS 1000
// clocks per oscillator cycle, derived from the two periods
`define BMC_OSC_CYCLES (`BMC_OSC_PERIOD_NS / `BMC_CLK_PERIOD_NS)
`define BMC_OSC_LAST 4'((`BMC_OSC_CYCLES) - 1)
// oscillator cycles a light-load flag must hold before pulse-frequency mode
`define BMC_QUAL_CYCLES 6'h20
// oscillator cycles spent on each soft-start current limit step
`define BMC_SS_STEP_CYCLES 8'h10
// current limit steps: 200 mA, 400 mA, 600 mA, 1220 mA (full)
`define BMC_ILIM_MIN 2'h0
`define BMC_ILIM_FULL 2'h3
`endif

// ---- buck_mode_pkg.sv ----
// types shared by the buck mode controller
package buck_mode_pkg;
	typedef enum logic [2:0] {
		SHUTDOWN, PWM_HIGH, PWM_LOW, TIMED_LIMIT, PFM_SLEEP, PFM_HIGH, PFM_LOW
	} state_t;
	// comparator and pin flags, all from outside the clock domain
	typedef struct packed {
		logic en;
		logic supply_ok;
		logic reg_trip;
		logic cur_limit;
		logic zero_cur;
		logic light_load;
		logic pfm_peak_current_limit;
		logic out_above_high;
		logic pfm_exit_threshold;
		logic short_det;
		logic low_current;
	} flags_t;
endpackage : buck_mode_pkg

// ---- buck_power_stage.sv ----
// behavioural power stage: inductor current ramp and the two current flags
module buck_power_stage (
	// clock and gates from the controller
	input wire logic i_clk,
	input wire logic i_high_gate,
	input wire logic i_low_gate,
	// on-time, in clocks, before the regulation comparator trips
	input wire logic [3:0] i_on_len,
	// comparator flags back to the controller
	output logic o_reg_trip,
	output logic o_zero_cur
);
	timeunit 1ns;
	timeprecision 1ns;
	int cur = 0;
	// current ramps up through the high side and decays through the low side
	always @(posedge i_clk) begin
		if (i_high_gate)
			cur <= cur + 1;
		else if (i_low_gate && cur > 0)
			cur <= cur - 1;
	end
	// a long on-length trips only after that many clocks of ramp, which stands in for a heavy load
	assign o_reg_trip = i_high_gate && cur >= int'(i_on_len);
	assign o_zero_cur = i_low_gate && cur == 0;
endmodule : buck_power_stage

// ---- buck_mode_controller_tb_top.sv ----
// self-checking bench for the buck mode controller
module buck_mode_controller_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk;
	logic i_rst_b;
	buck_mode_pkg::flags_t fl;
	logic [3:0] on_len;
	logic [31:0] seed;
	logic [1:0] step;
	logic [1:0] last;
	wire logic [5:0] outs;
	wire logic reg_trip;
	wire logic zero_cur;
	int miscompares = 0;
	int checked = 0;
	int n;
	int t;
	int ss_age = 0;
	int ss_exp;
	// output vector indices
	localparam int HG = 5, LG = 4, PM = 3, SL = 2, BE = 1, SS = 0;

	buck_mode_controller #(.SS_STEP_CYCLES(8'h02)) dut (
		.i_clk(i_clk), .i_rst_b(i_rst_b), .i_en(fl.en), .i_supply_ok(fl.supply_ok),
		.i_reg_trip(reg_trip), .i_cur_limit(fl.cur_limit), .i_zero_cur(zero_cur),
		.i_light_load(fl.light_load), .pfm_peak_current_limit_peak_current_limit(fl.pfm_peak_current_limit),
		.i_out_above_high(fl.out_above_high), .pfm_peak_current_limit_exit_threshold(fl.pfm_exit_threshold),
		.i_short_det(fl.short_det), .i_low_current(fl.low_current),
		.o_high_gate(outs[HG]), .o_low_gate(outs[LG]), .o_pfm_mode(outs[PM]),
		.o_sleep(outs[SL]), .o_bias_en(outs[BE]), .o_soft_start(outs[SS]),
		.o_ilim_step(step));
	buck_power_stage stage (.i_clk(i_clk), .i_high_gate(outs[HG]), .i_low_gate(outs[LG]),
		.i_on_len(on_len), .o_reg_trip(reg_trip), .o_zero_cur(zero_cur));

	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	function logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	task check_bit(input string name, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s exp %b got %b", name, e, g);
		end
	endtask : check_bit

	task check_step(input string name, input logic [1:0] e, input logic [1:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s exp %h got %h", name, e, g);
		end
	endtask : check_step

	// waits on settled outputs, bounded; n returns the clocks spent
	task expect_bit(input int k, input logic v, input int lim, input string name);
		n = 0;
		// called on a rising edge, step to the falling edge so the launch has settled
		if (i_clk === 1'b1)
			@(negedge i_clk);
		while (outs[k] !== v && n < lim) begin
			@(negedge i_clk);
			n++;
		end
		check_bit(name, v, outs[k]);
	endtask : expect_bit

	task report_and_stop;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	// watchdog: the whole sequence needs well under 2000 clocks
	initial begin
		repeat (6000) @(posedge i_clk);
		miscompares++;
		report_and_stop();
	end

	// soft-start model: oscillator starts one clock before bias shows, so the first step
	// lands 19 clocks after bias on, then every 20 clocks (two ten-clock cycles), held at full
	always @(negedge i_clk) begin
		ss_age = outs[BE] ? ss_age + 1 : 0;
		ss_exp = (ss_age / 20 > 3) ? 3 : ss_age / 20;
		check_step("model step", 2'(ss_exp), step);
		check_bit("model soft start", outs[BE] && ss_exp != 3, outs[SS]);
	end

	initial begin
		fl = '0;
		on_len = 4'h2;
		seed = 32'h01f2;
		i_rst_b = 1'b0;
		repeat (10) @(posedge i_clk);
		i_rst_b <= 1'b1;
		fl.en <= 1'b1; // supply not yet good
		repeat (20) @(negedge i_clk);
		check_step("outputs idle", 2'h0, {outs[BE], outs[HG]});
		check_bit("bias unqualified", 1'b0, outs[BE]);
		@(posedge i_clk);
		fl.en <= 1'b0; // enable held low until supply good
		fl.supply_ok <= 1'b1;
		repeat (5) @(posedge i_clk);
		fl.en <= 1'b1;
		expect_bit(BE, 1'b1, 8, "bias on");
		check_bit("soft start on", 1'b1, outs[SS]);
		check_step("first step", 2'h0, step);
		// step must climb by one every 20 clocks and hold at full
		last = 2'h0;
		t = 0;
		for (int i = 0; i < 100 && step !== 2'h3; i++) begin
			@(negedge i_clk);
			t++;
			if (step !== last) begin
				check_step("next step", last + 2'h1, step);
				if (last != 2'h0)
					check_bit("step gap", 1'b1, t == 20);
				last = step;
				t = 0;
			end
		end
		repeat (25) @(negedge i_clk);
		check_step("full step", 2'h3, step);
		check_bit("soft start done", 1'b0, outs[SS]);
		// pwm cycles with random on-times: period fixed at one oscillator cycle
		// start from a fresh rise, else the first period is measured from mid on-time
		expect_bit(HG, 1'b0, 12, "pwm low phase");
		expect_bit(HG, 1'b1, 12, "pwm high");
		for (int i = 0; i < 3; i++) begin
			seed = lfsr_next(seed);
			on_len <= 4'h1 + {2'h0, seed[1:0]};
			expect_bit(HG, 1'b0, 12, "pwm trip");
			t = n;
			check_bit("rectifier on", 1'b1, outs[LG]);
			expect_bit(HG, 1'b1, 12, "pwm next");
			check_bit("pwm period", 1'b1, t + n == 10);
		end
		// peak limit ends on-time; the on-length is raised while the high side is off, since
		// leftover current from a long random on-time could otherwise trip the comparator first
		expect_bit(HG, 1'b0, 12, "low before limit");
		@(posedge i_clk);
		on_len <= 4'hf;
		expect_bit(HG, 1'b1, 12, "high before limit");
		@(posedge i_clk);
		fl.cur_limit <= 1'b1;
		expect_bit(LG, 1'b1, 6, "limit low");
		check_bit("limit high off", 1'b0, outs[HG]);
		@(posedge i_clk);
		fl.cur_limit <= 1'b0;
		on_len <= 4'h2;
		// short: low side held across ticks until current decays
		fl.short_det <= 1'b1;
		repeat (6) @(negedge i_clk);
		for (int i = 0; i < 30; i++) begin
			@(negedge i_clk);
			check_step("short gates", 2'h1, {outs[HG], outs[LG]});
		end
		@(posedge i_clk);
		fl.short_det <= 1'b0;
		fl.low_current <= 1'b1;
		expect_bit(HG, 1'b1, 20, "short released");
		@(posedge i_clk);
		fl.low_current <= 1'b0;
		// light load held: pfm after 32 oscillator cycles, straight to sleep
		fl.light_load <= 1'b1;
		fl.out_above_high <= 1'b1;
		expect_bit(PM, 1'b1, 400, "pfm entry");
		check_bit("qual window", 1'b1, n >= 310 && n <= 345);
		expect_bit(SL, 1'b1, 20, "pfm sleep");
		@(posedge i_clk);
		fl.out_above_high <= 1'b0;
		expect_bit(HG, 1'b1, 6, "pfm pulse");
		@(posedge i_clk);
		fl.pfm_peak_current_limit <= 1'b1;
		expect_bit(LG, 1'b1, 6, "peak ends pulse");
		@(posedge i_clk);
		fl.pfm_peak_current_limit <= 1'b0;
		expect_bit(HG, 1'b1, 20, "pulse again");
		check_bit("low off at zero", 1'b0, outs[LG]);
		@(posedge i_clk);
		fl.out_above_high <= 1'b1;
		expect_bit(LG, 1'b1, 6, "ramp to zero");
		expect_bit(SL, 1'b1, 20, "sleep again");
		check_step("sleep gates", 2'h0, {outs[HG], outs[LG]});
		@(posedge i_clk);
		fl.pfm_exit_threshold <= 1'b1;
		expect_bit(PM, 1'b0, 6, "pfm exit");
		@(posedge i_clk);
		fl.pfm_exit_threshold <= 1'b0;
		fl.light_load <= 1'b0;
		fl.out_above_high <= 1'b0;
		// enable low shuts all down; the next rise restarts with soft start
		repeat (30) @(posedge i_clk);
		fl.en <= 1'b0;
		expect_bit(BE, 1'b0, 6, "shutdown");
		check_bit("all off", 1'b1, outs === 6'h00 && step === 2'h0);
		@(posedge i_clk);
		fl.en <= 1'b1;
		expect_bit(SS, 1'b1, 8, "restart soft");
		check_step("restart step", 2'h0, step);
		check_bit("restart pwm", 1'b0, outs[PM]);
		report_and_stop();
	end
endmodule : buck_mode_controller_tb_top
